// ==== logic/capc_pkg.sv ====
// shared constants for the adc enable and protection option registers
package capc_pkg;

  // register command codes
  localparam logic [7:0]  ADDR_ADC_CTRL   = 8'h35;
  localparam logic [7:0]  ADDR_PROT_OPT4  = 8'h36;

  // values after reset
  localparam logic [15:0] ADC_CTRL_RST    = 16'h2000;
  localparam logic [15:0] PROT_OPT4_RST   = 16'h0048;
  // writable bits of the protection register, status bits excluded
  localparam logic [15:0] PROT_OPT4_WMASK = 16'hfefc;

  // field positions in the protection register
  localparam int UVP_LSB       = 13;
  localparam int DITH_LSB      = 11;
  localparam int NOHIC_BIT     = 10;
  localparam int HOT_PROF_BIT  = 9;
  localparam int HOT_FLAG_BIT  = 8;
  localparam int DEG_LSB       = 6;

  // threshold and dither decode
  localparam logic [13:0] UV_BASE_MV     = 14'h0960;  // 2400 mV
  localparam logic [13:0] UV_STEP_MV     = 14'h0320;  // 800 mV per step
  localparam logic [2:0]  DITH_STEP_PCT  = 3'h2;      // 2 % per step
  localparam logic [2:0]  FAIL_LIMIT     = 3'h7;      // failed restarts before latch-off

  // times in their own units
  localparam real CLK_PERIOD_NS    = 4.0;
  localparam real DEG0_US          = 100.0;
  localparam real DEG1_MS          = 1.6;
  localparam real DEG2_MS          = 6.0;
  localparam real DEG3_MS          = 12.0;
  localparam real CONV_MS          = 25.0;
  localparam real FAIL_WINDOW_S    = 90.0;
  localparam real HICCUP_OFF_MS    = 10.0;
  localparam real RESTART_CHECK_MS = 1.0;

  // cycle counts: least times round up, longest times round down
  localparam longint DEG0_CYC    = longint'($ceil(DEG0_US * 1.0e3 / CLK_PERIOD_NS));
  localparam longint DEG1_CYC    = longint'($ceil(DEG1_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam longint DEG2_CYC    = longint'($ceil(DEG2_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam longint DEG3_CYC    = longint'($ceil(DEG3_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam longint CONV_CYC    = longint'($floor(CONV_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam longint WINDOW_CYC  = longint'($floor(FAIL_WINDOW_S * 1.0e9 / CLK_PERIOD_NS));
  localparam longint HIC_OFF_CYC = longint'($ceil(HICCUP_OFF_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam longint CHECK_CYC   = longint'($ceil(RESTART_CHECK_MS * 1.0e6 / CLK_PERIOD_NS));

  // converter restart policy states
  typedef enum logic [1:0] {
    CAPC_RUN,
    CAPC_OFF,
    CAPC_RETRY,
    CAPC_LATCHED
  } capc_state_t;

endpackage

// ==== logic/capc_regs.sv ====
// adc channel enables, under-voltage hiccup policy, dither, hot profile and deglitch
`timescale 1ns/1ns
`default_nettype none
module capc_regs
  import capc_pkg::*;
#(
  // deglitch counts, indexed by the filter time code
  parameter logic [3:0][23:0] DEG_CYCLES = {24'(capc_pkg::DEG3_CYC), 24'(capc_pkg::DEG2_CYC),
                                            24'(capc_pkg::DEG1_CYC), 24'(capc_pkg::DEG0_CYC)},
  parameter logic [23:0] CONV_CYCLES    = 24'(capc_pkg::CONV_CYC),
  parameter logic [35:0] WINDOW_CYCLES  = 36'(capc_pkg::WINDOW_CYC),
  parameter logic [35:0] HIC_OFF_CYCLES = 36'(capc_pkg::HIC_OFF_CYC),
  parameter logic [35:0] CHECK_CYCLES   = 36'(capc_pkg::CHECK_CYC)
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_RD,
  output var  logic [15:0] REG_RDATA,
  output var  logic        REG_RVALID,
  input  wire logic        LOW_POWER,
  input  wire logic        SYS_UV_DET,
  input  wire logic        VAP_DET,
  input  wire logic        DCHG2_CMP,
  output var  logic        CONVERTER_ON,
  output var  logic        CONVERTER_LATCHED,
  output var  logic [13:0] UV_THRESH_MV,
  output var  logic [2:0]  DITHER_PCT,
  output var  logic        PROCESSOR_HOT_ALERT,
  output var  logic        DCHG2_ALERT,
  output var  logic        ADC_BUSY,
  output var  logic [2:0]  ADC_CHANNEL,
  output var  logic        ADC_SAMPLE
);
  import capc_pkg::*;

  typedef struct packed {
    logic [15:0] adc;
    logic [15:0] opt;
    logic [15:0] rdata;
    logic        rvalid;
    logic [2:0]  uv_s;
    logic [2:0]  vap_s;
    logic [2:0]  dcmp_s;
    logic        uv_q;
    logic        vap_q;
    logic        dcmp_q;
    capc_state_t st;
    logic [35:0] tmr;
    logic [2:0]  fails;
    logic        win_act;
    logic [35:0] win_tmr;
    logic        conv_on;
    logic [13:0] uv_mv;
    logic [2:0]  dith;
    logic        hot;
    logic [23:0] deg_cnt;
    logic        dalert;
    logic        busy;
    logic [2:0]  ch;
    logic [23:0] scan_tmr;
    logic        sample;
    logic        latched;
  } capc_state_s_t;

  capc_state_s_t s_r;
  capc_state_s_t s_nxt;
  logic [23:0]   deg_lim;
  logic          hot_set;
  logic          opt_rd;
  logic [2:0]    nch;

  // next enabled channel above cur, wrapping, battery voltage first
  function automatic logic [2:0] next_ch(input logic [7:0] en, input logic [2:0] cur);
    logic [2:0] c;
    logic       hit;
    c = cur;
    hit = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      if (!hit && en[3'(cur + 3'(i))]) begin
        c = 3'(cur + 3'(i));
        hit = 1'b1;
      end
    end
    return c;
  endfunction

  always_comb begin
    s_nxt = s_r;
    deg_lim = DEG_CYCLES[1];
    nch = next_ch(s_r.adc[7:0], s_r.ch);
    // synchronisers: a level counts once second and third stages agree
    s_nxt.uv_s   = {s_r.uv_s[1:0], SYS_UV_DET};
    s_nxt.vap_s  = {s_r.vap_s[1:0], VAP_DET};
    s_nxt.dcmp_s = {s_r.dcmp_s[1:0], DCHG2_CMP};
    if (s_r.uv_s[1] == s_r.uv_s[2]) s_nxt.uv_q = s_r.uv_s[2];
    if (s_r.vap_s[1] == s_r.vap_s[2]) s_nxt.vap_q = s_r.vap_s[2];
    if (s_r.dcmp_s[1] == s_r.dcmp_s[2]) s_nxt.dcmp_q = s_r.dcmp_s[2];

    // register writes; status bits are not writable
    if (REG_WR && REG_ADDR == ADDR_ADC_CTRL) begin
      s_nxt.adc = REG_WDATA;
    end else if (REG_WR && REG_ADDR == ADDR_PROT_OPT4) begin
      s_nxt.opt = (REG_WDATA & PROT_OPT4_WMASK) | (s_r.opt & ~PROT_OPT4_WMASK);
    end

    // register reads answer one cycle later, unmapped codes read zero
    opt_rd = REG_RD && REG_ADDR == ADDR_PROT_OPT4;
    s_nxt.rvalid = REG_RD;
    if (REG_RD && REG_ADDR == ADDR_ADC_CTRL) begin
      s_nxt.rdata = s_r.adc;
    end else if (opt_rd) begin
      s_nxt.rdata = s_r.opt;
    end else begin
      s_nxt.rdata = 16'h0000;
    end

    // hot status: set wins over the clear by read
    hot_set = s_r.vap_q && s_r.opt[HOT_PROF_BIT];
    if (opt_rd && s_r.opt[HOT_FLAG_BIT]) s_nxt.opt[HOT_FLAG_BIT] = 1'b0;
    if (hot_set) s_nxt.opt[HOT_FLAG_BIT] = 1'b1;
    s_nxt.hot = hot_set;

    // decoded settings follow the register copy being written
    s_nxt.uv_mv = UV_BASE_MV + 14'(s_nxt.opt[UVP_LSB +: 3]) * UV_STEP_MV;
    s_nxt.dith  = 3'(s_nxt.opt[DITH_LSB +: 2]) * DITH_STEP_PCT;

    // discharge limit2 deglitch: comparator must hold for the full time
    case (s_r.opt[DEG_LSB +: 2])
      2'h0: deg_lim = DEG_CYCLES[0];
      2'h1: deg_lim = DEG_CYCLES[1];
      2'h2: deg_lim = DEG_CYCLES[2];
      default: deg_lim = DEG_CYCLES[3];
    endcase
    if (!s_r.dcmp_q) begin
      s_nxt.deg_cnt = 24'h000000;
      s_nxt.dalert = 1'b0;
    end else if (s_r.deg_cnt >= deg_lim - 24'h000001) begin
      s_nxt.dalert = 1'b1;
    end else begin
      s_nxt.deg_cnt = s_r.deg_cnt + 24'h000001;
    end

    // failure window: count expires after the window closes
    if (s_r.win_act && s_r.st != CAPC_LATCHED) begin
      if (s_r.win_tmr == WINDOW_CYCLES - 36'h1) begin
        s_nxt.win_act = 1'b0;
        s_nxt.fails = 3'h0;
      end else begin
        s_nxt.win_tmr = s_r.win_tmr + 36'h1;
      end
    end

    // restart policy after an under-voltage event
    s_nxt.tmr = s_r.tmr + 36'h1;
    case (s_r.st)
      CAPC_RUN: begin
        s_nxt.tmr = 36'h0;
        if (s_r.uv_q) begin
          s_nxt.conv_on = 1'b0;
          if (s_r.opt[NOHIC_BIT]) begin
            s_nxt.st = CAPC_LATCHED;
          end else begin
            s_nxt.st = CAPC_OFF;
          end
        end
      end
      CAPC_OFF: begin
        if (s_r.tmr == HIC_OFF_CYCLES - 36'h1) begin
          s_nxt.st = CAPC_RETRY;
          s_nxt.conv_on = 1'b1;
          s_nxt.tmr = 36'h0;
        end
      end
      CAPC_RETRY: begin
        if (s_r.tmr == CHECK_CYCLES - 36'h1) begin
          s_nxt.tmr = 36'h0;
          if (s_r.uv_q) begin
            // a restart that still sees under-voltage is a failure
            s_nxt.fails = s_nxt.fails + 3'h1;
            s_nxt.conv_on = 1'b0;
            if (!s_nxt.win_act) begin
              s_nxt.win_act = 1'b1;
              s_nxt.win_tmr = 36'h0;
            end
            if (s_nxt.fails == FAIL_LIMIT) begin
              s_nxt.st = CAPC_LATCHED;
            end else begin
              s_nxt.st = CAPC_OFF;
            end
          end else begin
            s_nxt.st = CAPC_RUN;
          end
        end
      end
      default: begin
        // latched off until power-on reset
        s_nxt.conv_on = 1'b0;
        s_nxt.tmr = 36'h0;
      end
    endcase

    // latch-off indication kept in its own flop so the pin is not decoded logic
    s_nxt.latched = (s_nxt.st == CAPC_LATCHED);

    // adc scan: one enabled channel at a time, fixed order
    s_nxt.sample = 1'b0;
    if (LOW_POWER || s_r.adc[7:0] == 8'h00) begin
      s_nxt.busy = 1'b0;
      s_nxt.scan_tmr = 24'h000000;
      s_nxt.ch = 3'h7;
    end else if (!s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.ch = nch;
      s_nxt.scan_tmr = 24'h000000;
    end else if (s_r.scan_tmr >= CONV_CYCLES - 24'h000001) begin
      s_nxt.sample = 1'b1;
      s_nxt.ch = nch;
      s_nxt.scan_tmr = 24'h000000;
    end else begin
      s_nxt.scan_tmr = s_r.scan_tmr + 24'h000001;
    end
  end

  // single state register; reset takes constants only
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_r <= '0;
      s_r.adc <= ADC_CTRL_RST;
      s_r.opt <= PROT_OPT4_RST;
      s_r.st <= CAPC_RUN;
      s_r.conv_on <= 1'b1;
      s_r.uv_mv <= UV_BASE_MV;
      s_r.ch <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign REG_RDATA           = s_r.rdata;
  assign REG_RVALID          = s_r.rvalid;
  assign CONVERTER_ON        = s_r.conv_on;
  assign CONVERTER_LATCHED   = s_r.latched;
  assign UV_THRESH_MV        = s_r.uv_mv;
  assign DITHER_PCT          = s_r.dith;
  assign PROCESSOR_HOT_ALERT = s_r.hot;
  assign DCHG2_ALERT         = s_r.dalert;
  assign ADC_BUSY            = s_r.busy;
  assign ADC_CHANNEL         = s_r.ch;
  assign ADC_SAMPLE          = s_r.sample;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  chk_adc_en_write: assert property (
    REG_WR && REG_ADDR == ADDR_ADC_CTRL |=> s_r.adc[7:0] == $past(REG_WDATA[7:0]))
    else $error("adc enable write lost");
  chk_uv_decode: assert property (
    UV_THRESH_MV == UV_BASE_MV + 14'(s_r.opt[UVP_LSB +: 3]) * UV_STEP_MV)
    else $error("undervolt threshold decode wrong");
  chk_hiccup_entry: assert property (
    s_r.st == CAPC_RUN && s_r.uv_q && !s_r.opt[NOHIC_BIT] |=> s_r.st == CAPC_OFF && !CONVERTER_ON)
    else $error("hiccup not entered");
  chk_fail_latch: assert property (
    s_r.st == CAPC_RETRY && s_r.tmr == CHECK_CYCLES - 36'h1 && s_r.uv_q && s_r.fails == 3'h6
    && !(s_r.win_act && s_r.win_tmr == WINDOW_CYCLES - 36'h1) |=> CONVERTER_LATCHED)
    else $error("seventh failure did not latch off");
  chk_no_hiccup: assert property (
    s_r.st == CAPC_RUN && s_r.uv_q && s_r.opt[NOHIC_BIT] |=> CONVERTER_LATCHED ##1 CONVERTER_LATCHED)
    else $error("hiccup disable ignored");
  chk_dither_map: assert property (
    DITHER_PCT == 3'(s_r.opt[DITH_LSB +: 2]) * DITH_STEP_PCT)
    else $error("dither range decode wrong");
  chk_hot_gate: assert property (
    !s_r.opt[HOT_PROF_BIT] |=> !PROCESSOR_HOT_ALERT)
    else $error("hot alert while profile off");
  chk_hot_flag_hold: assert property (
    s_r.opt[HOT_FLAG_BIT] && !opt_rd |=> s_r.opt[HOT_FLAG_BIT])
    else $error("hot flag dropped without read");
  chk_read_clear: assert property (
    opt_rd && s_r.opt[HOT_FLAG_BIT] && !hot_set |=> !s_r.opt[HOT_FLAG_BIT] && REG_RDATA[HOT_FLAG_BIT])
    else $error("read did not return and clear flag");
  chk_deglitch_hold: assert property (
    $rose(DCHG2_ALERT) |-> $past(s_r.dcmp_q) && $past(s_r.deg_cnt) >= $past(deg_lim) - 24'h000001)
    else $error("discharge alert before deglitch time");
  chk_conv_bound: assert property (
    s_r.scan_tmr < CONV_CYCLES)
    else $error("channel conversion overran");
  chk_low_power: assert property (
    LOW_POWER |=> !ADC_BUSY && !ADC_SAMPLE)
    else $error("adc active in low-power mode");
endmodule
`default_nettype wire

// ==== testbench/capc_host.sv ====
// host register port model standing in for the smbus engine
`timescale 1ns/1ns
`default_nettype none
module capc_host (
  input  wire logic        CLK,
  output var  logic [7:0]  REG_ADDR,
  output var  logic        REG_WR,
  output var  logic [15:0] REG_WDATA,
  output var  logic        REG_RD,
  input  wire logic [15:0] REG_RDATA,
  input  wire logic        REG_RVALID
);
  // idle: strobes low, released lines never keep the last value
  initial begin
    REG_ADDR = 8'hff;
    REG_WR = 1'b0;
    REG_WDATA = 16'hffff;
    REG_RD = 1'b0;
  end
  // one write strobe, held over exactly one taken edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(posedge CLK);
    #1;
    REG_WR = 1'b0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask
  // read: data and valid stand just after the taken edge, sampled #1 after it
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(posedge CLK);
    #1;
    REG_RD = 1'b0;
    REG_ADDR = ~a;
    d = REG_RDATA;
    v = REG_RVALID;
  endtask
endmodule
`default_nettype wire

// ==== testbench/test_capc_regs.sv ====
// self-checking bench for the adc enable and protection registers
`timescale 1ns/1ns
`default_nettype none
module test_capc_regs;
  import capc_pkg::*;
  logic CLK, RSTN, REG_WR, REG_RD, REG_RVALID, LOW_POWER, SYS_UV_DET, VAP_DET, DCHG2_CMP;
  logic CONVERTER_ON, CONVERTER_LATCHED, HOT, DCHG2_ALERT, ADC_BUSY, ADC_SAMPLE;
  logic [7:0]  REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic [13:0] UV_THRESH_MV;
  logic [2:0]  DITHER_PCT, ADC_CHANNEL;
  int          n_errors = 0;
  int          num_checks = 0;

  capc_host i_capc_host (.CLK(CLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID));
  // short counts keep the run small
  capc_regs #(.DEG_CYCLES({24'd20, 24'd15, 24'd10, 24'd5}), .CONV_CYCLES(24'd16),
    .WINDOW_CYCLES(36'd2000), .HIC_OFF_CYCLES(36'd8),
    .CHECK_CYCLES(36'd4)) i_capc_regs (.CLK(CLK), .RSTN(RSTN),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LOW_POWER(LOW_POWER),
    .SYS_UV_DET(SYS_UV_DET), .VAP_DET(VAP_DET), .DCHG2_CMP(DCHG2_CMP),
    .CONVERTER_ON(CONVERTER_ON), .CONVERTER_LATCHED(CONVERTER_LATCHED),
    .UV_THRESH_MV(UV_THRESH_MV), .DITHER_PCT(DITHER_PCT), .PROCESSOR_HOT_ALERT(HOT),
    .DCHG2_ALERT(DCHG2_ALERT), .ADC_BUSY(ADC_BUSY), .ADC_CHANNEL(ADC_CHANNEL),
    .ADC_SAMPLE(ADC_SAMPLE));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    logic        v;
    i_capc_host.rd(a, d, v);
    chk({nm, " valid"}, 16'h1, {15'h0, v});
    chk(nm, e, d);
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // reset held three cycles, released just after an edge
  task automatic do_reset();
    RSTN = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    RSTN = 1'b1;
  endtask

  // reset values, every threshold and dither code, refused bits, unmapped code
  task automatic t_fields();
    rchk(ADDR_ADC_CTRL, 16'h2000, "adc ctrl reset");
    rchk(ADDR_PROT_OPT4, 16'h0048, "prot reset");
    for (int c = 0; c < 8; c++) begin
      i_capc_host.wr(ADDR_PROT_OPT4, 16'((c << 13) | ((c & 3) << 11)));
      chk("uv mv", 16'(2400 + 800 * c), 16'(UV_THRESH_MV));
      chk("dither", 16'(2 * (c & 3)), 16'(DITHER_PCT));
    end
    i_capc_host.wr(ADDR_PROT_OPT4, 16'hffff);
    rchk(ADDR_PROT_OPT4, 16'hfefc, "status bits read-only");
    i_capc_host.wr(ADDR_ADC_CTRL, 16'h00ff);
    rchk(ADDR_ADC_CTRL, 16'h00ff, "adc enables");
    rchk(8'h40, 16'h0000, "unmapped");
  endtask

  // hot alert gated by bit 9, flag latched until read, then cleared
  task automatic t_hot();
    i_capc_host.wr(ADDR_PROT_OPT4, 16'h0000);
    VAP_DET = 1'b1;
    repeat (8) @(posedge CLK) #1;
    chk("hot gated off", 16'h0, {15'h0, HOT});
    rchk(ADDR_PROT_OPT4, 16'h0000, "flag gated off");
    i_capc_host.wr(ADDR_PROT_OPT4, 16'h0200);
    // alert follows the profile bit one clock after it is written
    @(posedge CLK) #1;
    chk("hot on", 16'h1, {15'h0, HOT});
    VAP_DET = 1'b0;
    repeat (8) @(posedge CLK);
    #1;
    chk("hot drops", 16'h0, {15'h0, HOT});
    rchk(ADDR_PROT_OPT4, 16'h0300, "flag latched");
    rchk(ADDR_PROT_OPT4, 16'h0200, "flag cleared");
  endtask

  // each deglitch code: alert only after its time plus the input sync
  task automatic t_deg();
    int n;
    for (int c = 0; c < 4; c++) begin
      i_capc_host.wr(ADDR_PROT_OPT4, 16'(c << 6));
      DCHG2_CMP = 1'b1;
      for (n = 0; n < 40 && DCHG2_ALERT !== 1'b1; n++) @(posedge CLK) #1;
      chk("deglitch early", 16'h1, 16'(n >= 5 * (c + 1) + 3));
      chk("deglitch late", 16'h1, 16'(n <= 5 * (c + 1) + 5));
      DCHG2_CMP = 1'b0;
      repeat (8) @(posedge CLK);
    end
  endtask

  // low power holds the adc off; scan in order, one conversion time each
  task automatic t_adc();
    int n;
    i_capc_host.wr(ADDR_ADC_CTRL, 16'h2005);
    repeat (4) @(posedge CLK) #1;
    chk("adc off in low power", 16'h0, {15'h0, ADC_BUSY});
    LOW_POWER = 1'b0;
    repeat (2) @(posedge CLK) #1;
    chk("first channel", 16'h0, 16'(ADC_CHANNEL));
    for (n = 0; n < 40 && ADC_SAMPLE !== 1'b1; n++) @(posedge CLK) #1;
    chk("next channel", 16'h2, 16'(ADC_CHANNEL));
    n = 1;
    @(posedge CLK) #1;
    while (n < 40 && ADC_SAMPLE !== 1'b1) begin
      @(posedge CLK) #1;
      n++;
    end
    chk("conversion time", 16'd16, 16'(n));
    chk("wrap channel", 16'h0, 16'(ADC_CHANNEL));
    LOW_POWER = 1'b1;
    repeat (2) @(posedge CLK) #1;
    chk("adc stops", 16'h0, {15'h0, ADC_BUSY});
  endtask

  // persistent under-voltage: seven restarts then latch; with no hiccup, latch at once
  task automatic t_uv(input logic nohic);
    int   n;
    int   rises;
    logic was_on;
    i_capc_host.wr(ADDR_PROT_OPT4, {5'h0, nohic, 10'h048});
    SYS_UV_DET = 1'b1;
    rises = 0;
    was_on = CONVERTER_ON;
    for (n = 0; n < 400 && CONVERTER_LATCHED !== 1'b1; n++) begin
      @(posedge CLK);
      #1;
      // each restart attempt shows as a rise of the converter enable
      if (CONVERTER_ON === 1'b1 && was_on === 1'b0)
        rises++;
      was_on = CONVERTER_ON;
    end
    chk("latched", 16'h1, {15'h0, CONVERTER_LATCHED});
    chk("restarts", nohic ? 16'h0 : 16'h7, 16'(rises));
    chk("latch time", 16'h1, 16'(nohic ? n <= 10 : (n >= 72 && n <= 300)));
    SYS_UV_DET = 1'b0;
    repeat (10) @(posedge CLK) #1;
    chk("stays off", 16'h0, {15'h0, CONVERTER_ON});
    do_reset();
  endtask

  // watchdog reckoned from about 330 cycles of tests
  initial begin
    #40000;
    n_errors++;
    stop_test();
  end

  initial begin
    RSTN = 1'b0;
    LOW_POWER = 1'b1;
    SYS_UV_DET = 1'b0;
    VAP_DET = 1'b0;
    DCHG2_CMP = 1'b0;
    do_reset();
    t_fields();
    t_hot();
    t_deg();
    t_adc();
    t_uv(1'b0);
    t_uv(1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
